// File: verilog/asf_pkg.sv
/*
 * Shared constants and types of the arithmetic status flag block:
 * register indexes and byte addresses, flag positions, reset values,
 * operation codes. Assumes a 32-bit Avalon-MM register bus.
 */
`default_nettype none
package asf_pkg;
    localparam int unsigned ADDR_W = 14;
    // register indexes; byte address is four times the index
    localparam logic [11:0] STATUS_IDX = 12'h4D8;
    localparam logic [11:0] MULTIPLY_PRODUCT_IDX = 12'h4F3;
    localparam logic [11:0] MULTIPLY_PRODUCT_HIGH_IDX = 12'h4F4;
    localparam logic [13:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    localparam logic [13:0] MULTIPLY_PRODUCT_ADDR = {MULTIPLY_PRODUCT_IDX, 2'b00};
    localparam logic [13:0] MULTIPLY_PRODUCT_HIGH_ADDR = {MULTIPLY_PRODUCT_HIGH_IDX, 2'b00};
    // flag positions in the status register
    localparam int unsigned TO_BIT = 6;
    localparam int unsigned PD_BIT = 5;
    localparam int unsigned N_BIT = 4;
    localparam int unsigned OV_BIT = 3;
    localparam int unsigned Z_BIT = 2;
    localparam int unsigned DC_BIT = 1;
    localparam int unsigned C_BIT = 0;
    // reset values
    localparam logic POWER_FLAG_RESET = 1'b1;
    localparam logic [4:0] ARITH_RESET = 5'h00;
    localparam logic [7:0] MULTIPLY_PRODUCT_HIGH_RESET = 8'h00;
    // cycles from reset release until reset cause is sampled
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    typedef enum logic [3:0] {
        ASF_OP_NONE,
        ASF_OP_ADD,
        ASF_OP_SUB,
        ASF_OP_AND,
        ASF_OP_IOR,
        ASF_OP_XOR,
        ASF_OP_RLC,
        ASF_OP_RRC,
        ASF_OP_MUL,
        ASF_OP_CLEAR_WATCHDOG_INSTR,
        ASF_OP_SLEEP
    } asf_op_t;
endpackage
`default_nettype wire

// File: verilog/asf_sync.sv
/*
 * Two flip-flop level synchroniser, parameterised width.
 * Assumes inputs are slow levels from outside the clock domain.
 */
`default_nettype none
module asf_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: verilog/asf_alu.sv
/*
 * Combinational 8-bit ALU: result, flag values and the mask of flags
 * each operation affects. Flag vector order is {n, ov, z, dc, c}.
 * Assumes the caller registers everything it uses.
 */
`default_nettype none
module asf_alu (
    input wire asf_pkg::asf_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic [4:0] flags,
    output logic [4:0] flag_mask,
    output logic has_result
);
    wire is_add = (op == asf_pkg::ASF_OP_ADD);
    wire is_sub = (op == asf_pkg::ASF_OP_SUB);
    wire is_arith = is_add | is_sub;
    wire is_rlc = (op == asf_pkg::ASF_OP_RLC);
    wire is_rrc = (op == asf_pkg::ASF_OP_RRC);
    // subtract as add of the two's complement: carries become inverted borrows
    wire [7:0] b_eff = is_sub ? ~b : b;
    wire cin = is_sub;
    wire [8:0] sum9 = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    wire [4:0] low5 = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    wire ov = (a[7] == b_eff[7]) && (sum9[7] != a[7]);
    wire rot_out = is_rlc ? a[7] : a[0];

    assign result = is_arith ? sum9[7:0] :
                    (op == asf_pkg::ASF_OP_AND) ? (a & b) :
                    (op == asf_pkg::ASF_OP_IOR) ? (a | b) :
                    (op == asf_pkg::ASF_OP_XOR) ? (a ^ b) :
                    is_rlc ? {a[6:0], carry_in} :
                    is_rrc ? {carry_in, a[7:1]} : 8'h00;
    assign flags = {result[7], ov, (result == 8'h00), low5[4],
                    is_arith ? sum9[8] : rot_out};
    assign flag_mask = is_arith ? 5'h1F :
                       (is_rlc | is_rrc) ? 5'h15 :
                       ((op == asf_pkg::ASF_OP_AND) || (op == asf_pkg::ASF_OP_IOR) ||
                        (op == asf_pkg::ASF_OP_XOR)) ? 5'h14 : 5'h00;
    assign has_result = (flag_mask != 5'h00);
endmodule
`default_nettype wire

// File: verilog/asf_status_flags.sv
/*
 * Arithmetic status flag register and 16-bit product register, with an
 * Avalon-MM slave (waitrequest) for software access. Assumes execution
 * inputs come from logic on the same clock, reset cause pins are async.
 */
`default_nettype none
module asf_status_flags (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [13:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic exec_valid,
    input wire asf_pkg::asf_op_t exec_op,
    input wire logic [7:0] exec_operand_a,
    input wire logic [7:0] exec_operand_b,
    input wire logic exec_dest_is_status,
    input wire logic wdt_expired,
    input wire logic power_on_brownout_reset_cause,
    input wire logic wdt_reset_cause,
    input wire logic sleep_reset_cause,
    output logic [7:0] exec_result,
    output logic exec_result_valid,
    output logic [7:0] status_flags_out,
    output logic [15:0] product_out
);
    logic [1:0] init_cnt;
    logic init_done;
    logic [2:0] cause_sync;
    logic watchdog_timeout_flag;
    logic powerdown_flag;
    logic [4:0] arith_flags;
    logic [7:0] product_high_byte;
    logic [7:0] product_low_byte;
    logic [7:0] alu_result;
    logic [4:0] alu_flags;
    logic [4:0] alu_mask;
    logic alu_has_result;

    asf_sync #(.WIDTH(3)) u_cause_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in({power_on_brownout_reset_cause, wdt_reset_cause, sleep_reset_cause}),
        .sync_out(cause_sync)
    );

    asf_alu u_alu (
        .op(exec_op),
        .a(exec_operand_a),
        .b(exec_operand_b),
        .carry_in(arith_flags[asf_pkg::C_BIT]),
        .result(alu_result),
        .flags(alu_flags),
        .flag_mask(alu_mask),
        .has_result(alu_has_result)
    );

    // bus decode
    wire bus_req = read | write;
    wire hit_status = (address == asf_pkg::STATUS_ADDR);
    wire hit_multiply_product = (address == asf_pkg::MULTIPLY_PRODUCT_ADDR);
    wire hit_multiply_product_high = (address == asf_pkg::MULTIPLY_PRODUCT_HIGH_ADDR);
    wire bus_accept = bus_req & waitrequest & init_done;
    wire bus_wr = write & ~waitrequest;
    wire sw_wr_status = bus_wr & hit_status & byteenable[0];
    // product word: lane 0 low byte, lane 1 high byte; alias holds high in lane 0
    wire sw_wr_multiply_product_low = bus_wr & hit_multiply_product & byteenable[0];
    wire sw_wr_multiply_product_high = bus_wr & ((hit_multiply_product & byteenable[1]) |
                                     (hit_multiply_product_high & byteenable[0]));
    wire [31:0] rd_value = hit_status ? {24'h000000, status_flags_out} :
                           hit_multiply_product ? {16'h0000, product_high_byte, product_low_byte} :
                           hit_multiply_product_high ? {24'h000000, product_high_byte} : 32'h00000000;

    // execution decode
    wire exec_fire = exec_valid & init_done;
    wire [4:0] exec_mask = exec_fire ? alu_mask : 5'h00;
    wire do_clear_watchdog_instr = exec_fire && (exec_op == asf_pkg::ASF_OP_CLEAR_WATCHDOG_INSTR);
    wire do_sleep = exec_fire && (exec_op == asf_pkg::ASF_OP_SLEEP);
    wire do_mul = exec_fire && (exec_op == asf_pkg::ASF_OP_MUL);
    wire [15:0] mul_product = {8'h00, exec_operand_a} * {8'h00, exec_operand_b};
    wire init_last = ~init_done && (init_cnt == asf_pkg::INIT_CYCLES - 2'h1);
    wire por_init = init_last & cause_sync[2];

    // flag merge
    // execution wins over a software write in the same cycle for the flags its operation affects
    wire [4:0] sw_arith = sw_wr_status ? writedata[4:0] : arith_flags;
    wire [4:0] next_arith = por_init ? asf_pkg::ARITH_RESET :
                            ((exec_mask & alu_flags) | (~exec_mask & sw_arith));

    wire next_to = init_last ? (cause_sync[2] | ~cause_sync[1]) :
                   wdt_expired ? 1'b0 :
                   (do_clear_watchdog_instr | do_sleep) ? 1'b1 : watchdog_timeout_flag;
    wire next_pd = init_last ? (cause_sync[2] | ~cause_sync[0]) :
                   do_sleep ? 1'b0 :
                   do_clear_watchdog_instr ? 1'b1 : powerdown_flag;

    wire [7:0] next_multiply_product_high = por_init ? asf_pkg::MULTIPLY_PRODUCT_HIGH_RESET :
                                do_mul ? mul_product[15:8] :
                                sw_wr_multiply_product_high ? (hit_multiply_product ? writedata[15:8] : writedata[7:0]) :
                                product_high_byte;
    wire [7:0] next_multiply_product_low = do_mul ? mul_product[7:0] :
                               sw_wr_multiply_product_low ? writedata[7:0] : product_low_byte;

    // result dropped when status is target
    wire next_result_valid = exec_fire & alu_has_result & ~exec_dest_is_status;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            init_cnt <= 2'h0;
            init_done <= 1'b0;
        end else if (!init_done) begin
            init_cnt <= init_cnt + 2'h1;
            init_done <= init_last;
        end
    end

    // flags keep their value across a reset; only the cause decides
    // cause-dependent load
    always_ff @(posedge clock) begin
        watchdog_timeout_flag <= next_to;
        powerdown_flag <= next_pd;
        arith_flags <= next_arith;
        product_high_byte <= next_multiply_product_high;
        product_low_byte <= next_multiply_product_low;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
            exec_result <= 8'h00;
            exec_result_valid <= 1'b0;
        end else begin
            waitrequest <= ~bus_accept;
            readdata <= (bus_accept & read) ? rd_value : readdata;
            exec_result <= next_result_valid ? alu_result : exec_result;
            exec_result_valid <= next_result_valid;
        end
    end

    assign status_flags_out = {1'b0, watchdog_timeout_flag, powerdown_flag, arith_flags};
    assign product_out = {product_high_byte, product_low_byte};

    property p_clear_watchdog_instr_sets;
        @(posedge clock) disable iff (!rstn)
        do_clear_watchdog_instr && !wdt_expired |=> watchdog_timeout_flag && powerdown_flag;
    endproperty
    a_clear_watchdog_instr_sets: assert property (p_clear_watchdog_instr_sets) else $error("clear_watchdog_instr flags");

    property p_sleep_flags;
        @(posedge clock) disable iff (!rstn)
        do_sleep && !wdt_expired |=> watchdog_timeout_flag && !powerdown_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags");

    property p_expiry_clears;
        @(posedge clock) disable iff (!rstn)
        wdt_expired && init_done |=> !watchdog_timeout_flag;
    endproperty
    a_expiry_clears: assert property (p_expiry_clears) else $error("expiry to");

    property p_por_values;
        @(posedge clock) disable iff (!rstn)
        por_init |=> status_flags_out == 8'h60 && init_done;
    endproperty
    a_por_values: assert property (p_por_values) else $error("por status");

    property p_add_carry;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_ADD |=>
            arith_flags[asf_pkg::C_BIT] ==
            (({1'b0, $past(exec_operand_a)} + {1'b0, $past(exec_operand_b)}) > 9'h0FF) &&
            arith_flags[asf_pkg::DC_BIT] ==
            (({1'b0, $past(exec_operand_a[3:0])} + {1'b0, $past(exec_operand_b[3:0])}) > 5'h0F);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry");

    property p_sub_borrow;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_SUB |=>
            arith_flags[asf_pkg::C_BIT] == ($past(exec_operand_a) >= $past(exec_operand_b));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow");

    property p_zero_neg;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_AND |=>
            arith_flags[asf_pkg::Z_BIT] ==
            (($past(exec_operand_a) & $past(exec_operand_b)) == 8'h00)
            && arith_flags[asf_pkg::N_BIT] ==
            ($past(exec_operand_a[7]) & $past(exec_operand_b[7]));
    endproperty
    a_zero_neg: assert property (p_zero_neg) else $error("zero/neg");

    property p_overflow;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_ADD && exec_operand_a == 8'h7F &&
            exec_operand_b == 8'h01 |=> arith_flags[asf_pkg::OV_BIT] && arith_flags[asf_pkg::N_BIT];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow");

    property p_rotate_carry;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_RLC |=>
            arith_flags[asf_pkg::C_BIT] == $past(exec_operand_a[7]);
    endproperty
    a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry");

    property p_status_dest;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_dest_is_status |=> !exec_result_valid;
    endproperty
    a_status_dest: assert property (p_status_dest) else $error("status dest");

    property p_power_ro;
        @(posedge clock) disable iff (!rstn)
        sw_wr_status && !exec_fire && !wdt_expired |=>
            $stable(watchdog_timeout_flag) && $stable(powerdown_flag) && !status_flags_out[7];
    endproperty
    a_power_ro: assert property (p_power_ro) else $error("power flags written");

    property p_multiply_product_high;
        @(posedge clock) disable iff (!rstn)
        sw_wr_multiply_product_high && hit_multiply_product_high && !do_mul |=> product_high_byte == $past(writedata[7:0]);
    endproperty
    a_multiply_product_high: assert property (p_multiply_product_high) else $error("product high");

    property p_rrc_carry;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_RRC |=>
            arith_flags[asf_pkg::C_BIT] == $past(exec_operand_a[0]);
    endproperty
    a_rrc_carry: assert property (p_rrc_carry) else $error("rrc carry");

    property p_rotate_fill;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_RLC && !exec_dest_is_status |=>
            exec_result == {$past(exec_operand_a[6:0]), $past(arith_flags[asf_pkg::C_BIT])};
    endproperty
    a_rotate_fill: assert property (p_rotate_fill) else $error("rotate fill");

    property p_sub_digit;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_SUB |=>
            arith_flags[asf_pkg::DC_BIT] ==
            ($past(exec_operand_a[3:0]) >= $past(exec_operand_b[3:0]));
    endproperty
    a_sub_digit: assert property (p_sub_digit) else $error("sub digit");

    property p_no_overflow;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_ADD &&
            exec_operand_a[7] != exec_operand_b[7] |=> !arith_flags[asf_pkg::OV_BIT];
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("no overflow");

    property p_xor_flags;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_op == asf_pkg::ASF_OP_XOR |=>
            arith_flags[asf_pkg::N_BIT] == ($past(exec_operand_a[7]) ^ $past(exec_operand_b[7]))
            && arith_flags[asf_pkg::Z_BIT] == ($past(exec_operand_a) == $past(exec_operand_b));
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor flags");

    property p_mul_product;
        @(posedge clock) disable iff (!rstn)
        do_mul |=> product_out ==
            {8'h00, $past(exec_operand_a)} * {8'h00, $past(exec_operand_b)};
    endproperty
    a_mul_product: assert property (p_mul_product) else $error("mul product");

    property p_status_read;
        @(posedge clock) disable iff (!rstn)
        read && hit_status && waitrequest && init_done |=> !waitrequest &&
            readdata == {24'h000000, $past(status_flags_out)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read");

    property p_multiply_product_low;
        @(posedge clock) disable iff (!rstn)
        sw_wr_multiply_product_low && !do_mul |=> product_low_byte == $past(writedata[7:0]);
    endproperty
    a_multiply_product_low: assert property (p_multiply_product_low) else $error("product low");

    property p_sw_arith;
        @(posedge clock) disable iff (!rstn)
        sw_wr_status && !exec_fire |=> arith_flags == $past(writedata[4:0]);
    endproperty
    a_sw_arith: assert property (p_sw_arith) else $error("status write");

    property p_dest_flags;
        @(posedge clock) disable iff (!rstn)
        exec_fire && exec_dest_is_status && exec_op == asf_pkg::ASF_OP_AND |=>
            arith_flags[asf_pkg::Z_BIT] ==
            (($past(exec_operand_a) & $past(exec_operand_b)) == 8'h00);
    endproperty
    a_dest_flags: assert property (p_dest_flags) else $error("dest flags");

    property p_nonpor_load;
        @(posedge clock) disable iff (!rstn)
        init_last && !cause_sync[2] |=> arith_flags == $past(arith_flags) &&
            watchdog_timeout_flag == !$past(cause_sync[1]) &&
            powerdown_flag == !$past(cause_sync[0]);
    endproperty
    a_nonpor_load: assert property (p_nonpor_load) else $error("reset cause");
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
 * Self-checking bench of the status flag block: corner and random
 * instructions, bus access to status and product, three reset causes.
 * Assumes the block alone on one 50 MHz clock, bench as bus master.
 */
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ps;
logic clock = 1'b0;
logic rstn = 1'b0;
logic [13:0] address = 14'h0000;
logic read = 1'b0;
logic write = 1'b0;
logic [31:0] writedata = 32'h0000_0000;
logic [3:0] byteenable = 4'h0;
logic [31:0] readdata;
logic waitrequest;
logic exec_valid = 1'b0;
asf_pkg::asf_op_t exec_op = asf_pkg::ASF_OP_NONE;
logic [7:0] exec_operand_a = 8'h00;
logic [7:0] exec_operand_b = 8'h00;
logic exec_dest_is_status = 1'b0;
logic wdt_expired = 1'b0;
logic power_on_brownout_reset_cause = 1'b1;
logic wdt_reset_cause = 1'b0;
logic sleep_reset_cause = 1'b0;
logic [7:0] exec_result;
logic exec_result_valid;
logic [7:0] status_flags_out;
logic [15:0] product_out;
int fail_count = 0;
int num_checks = 0;
logic [31:0] seed = 32'h0000_0032;
logic [7:0] st;
logic [31:0] rd;
asf_pkg::asf_op_t ops [8] = '{asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB, asf_pkg::ASF_OP_AND,
    asf_pkg::ASF_OP_IOR, asf_pkg::ASF_OP_XOR, asf_pkg::ASF_OP_RLC, asf_pkg::ASF_OP_RRC,
    asf_pkg::ASF_OP_SUB};

always #10 clock = ~clock;

asf_status_flags u_asf_status_flags (.clock(clock), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .exec_valid(exec_valid),
    .exec_op(exec_op), .exec_operand_a(exec_operand_a), .exec_operand_b(exec_operand_b),
    .exec_dest_is_status(exec_dest_is_status), .wdt_expired(wdt_expired),
    .power_on_brownout_reset_cause(power_on_brownout_reset_cause), .wdt_reset_cause(wdt_reset_cause),
    .sleep_reset_cause(sleep_reset_cause), .exec_result(exec_result),
    .exec_result_valid(exec_result_valid), .status_flags_out(status_flags_out),
    .product_out(product_out));

function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
endfunction

// returns {result, next status}; subtraction carries are no-borrow flags
function automatic logic [15:0] ref_exec(input asf_pkg::asf_op_t op, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] s);
    logic [8:0] sum;
    logic [7:0] r;
    logic [7:0] n;
    n = s;
    r = 8'h00;
    case (op)
        asf_pkg::ASF_OP_ADD: begin
            sum = {1'b0, a} + {1'b0, b};
            r = sum[7:0];
            n[3] = (a[7] == b[7]) && (r[7] != a[7]);
            n[1] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
            n[0] = sum[8];
        end
        asf_pkg::ASF_OP_SUB: begin
            r = a - b;
            n[3] = (a[7] != b[7]) && (r[7] != a[7]);
            n[1] = a[3:0] >= b[3:0];
            n[0] = a >= b;
        end
        asf_pkg::ASF_OP_AND: r = a & b;
        asf_pkg::ASF_OP_IOR: r = a | b;
        asf_pkg::ASF_OP_XOR: r = a ^ b;
        asf_pkg::ASF_OP_RLC: begin
            r = {a[6:0], s[0]};
            n[0] = a[7];
        end
        asf_pkg::ASF_OP_RRC: begin
            r = {s[0], a[7:1]};
            n[0] = a[0];
        end
        asf_pkg::ASF_OP_CLEAR_WATCHDOG_INSTR: n[6:5] = 2'h3;
        asf_pkg::ASF_OP_SLEEP: n[6:5] = 2'h2;
        default: n = s;
    endcase
    if (op inside {ops}) begin
        n[4] = r[7];
        n[2] = r == 8'h00;
    end
    return {r, n};
endfunction

task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask

task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
        fail_count++;
        $display("Error %s expected %h seen %h", what, exp, got);
    end
endtask

// holds the request until waitrequest is sampled low at a rising edge
task automatic bus(input logic wr, input logic [13:0] adr, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    @(posedge clock);
    address <= adr;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    n = 0;
    do begin
        @(posedge clock);
        n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
        fail_count++;
        summarize();
    end
endtask

task automatic ex(input asf_pkg::asf_op_t op, input logic [7:0] a, input logic [7:0] b,
    input logic ds);
    logic [15:0] e;
    logic has;
    e = ref_exec(op, a, b, st);
    has = (op inside {ops}) && !ds;
    @(posedge clock);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_operand_a <= a;
    exec_operand_b <= b;
    exec_dest_is_status <= ds;
    @(posedge clock);
    exec_valid <= 1'b0;
    #1;
    chk("status_flags_out", 32'(e[7:0]), 32'(status_flags_out));
    chk("exec_result_valid", 32'(has), 32'(exec_result_valid));
    if (has) begin
        chk("exec_result", 32'(e[15:8]), 32'(exec_result));
    end
    st = e[7:0];
endtask

task automatic do_reset(input logic por, input logic wdc, input logic slc);
    @(posedge clock);
    power_on_brownout_reset_cause <= por;
    wdt_reset_cause <= wdc;
    sleep_reset_cause <= slc;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
endtask

initial begin
    do_reset(1'b1, 1'b0, 1'b0);
    st = 8'h60;
    chk("status_por", 32'h0000_0060, 32'(status_flags_out));
    bus(1'b0, asf_pkg::STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk("status_read", 32'h0000_0060, rd);
    $display("test power-on done");
    ex(asf_pkg::ASF_OP_ADD, 8'h7F, 8'h01, 1'b0);
    ex(asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 1'b0);
    ex(asf_pkg::ASF_OP_SUB, 8'h00, 8'h01, 1'b0);
    ex(asf_pkg::ASF_OP_SUB, 8'h80, 8'h01, 1'b0);
    ex(asf_pkg::ASF_OP_SUB, 8'h10, 8'h10, 1'b0);
    ex(asf_pkg::ASF_OP_RLC, 8'h80, 8'h00, 1'b0);
    ex(asf_pkg::ASF_OP_RRC, 8'h01, 8'h00, 1'b0);
    ex(asf_pkg::ASF_OP_AND, 8'hF0, 8'h0F, 1'b1);
    for (int i = 0; i < 200; i++) begin
        seed = xs(seed);
        ex(ops[seed[2:0]], seed[15:8], seed[23:16], seed[31:29] == 3'h7);
    end
    $display("test arithmetic done");
    ex(asf_pkg::ASF_OP_SLEEP, 8'h00, 8'h00, 1'b0);
    @(posedge clock);
    wdt_expired <= 1'b1;
    @(posedge clock);
    wdt_expired <= 1'b0;
    #1;
    st[6] = 1'b0;
    chk("timeout_flag", 32'(st), 32'(status_flags_out));
    ex(asf_pkg::ASF_OP_CLEAR_WATCHDOG_INSTR, 8'h00, 8'h00, 1'b0);
    $display("test power flags done");
    ex(asf_pkg::ASF_OP_MUL, 8'hFF, 8'hFF, 1'b0);
    chk("product_out", 32'h0000_FE01, 32'(product_out));
    bus(1'b0, asf_pkg::MULTIPLY_PRODUCT_ADDR, 32'h0000_0000, 4'hF);
    chk("product_read", 32'h0000_FE01, rd);
    bus(1'b1, asf_pkg::MULTIPLY_PRODUCT_ADDR, 32'h0000_1234, 4'h3);
    bus(1'b0, asf_pkg::MULTIPLY_PRODUCT_HIGH_ADDR, 32'h0000_0000, 4'hF);
    chk("product_high", 32'h0000_0012, rd);
    chk("product_wr", 32'h0000_1234, 32'(product_out));
    bus(1'b1, asf_pkg::MULTIPLY_PRODUCT_HIGH_ADDR, 32'h0000_00AB, 4'h1);
    bus(1'b0, asf_pkg::MULTIPLY_PRODUCT_ADDR, 32'h0000_0000, 4'hF);
    chk("product_alias", 32'h0000_AB34, rd);
    $display("test product done");
    bus(1'b1, asf_pkg::STATUS_ADDR, 32'h0000_00FF, 4'h1);
    st = {1'b0, st[6:5], 5'h1F};
    bus(1'b1, 14'h0100, 32'h0000_0000, 4'hF);
    bus(1'b0, 14'h0100, 32'h0000_0000, 4'hF);
    chk("unmapped_read", 32'h0000_0000, rd);
    bus(1'b0, asf_pkg::STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk("status_sw", 32'(st), rd);
    $display("test status bus done");
    do_reset(1'b0, 1'b1, 1'b0);
    st = {3'h1, st[4:0]};
    chk("status_wdt_reset", 32'(st), 32'(status_flags_out));
    do_reset(1'b0, 1'b0, 1'b1);
    st = {3'h2, st[4:0]};
    chk("status_sleep_reset", 32'(st), 32'(status_flags_out));
    $display("test other reset done");
    summarize();
end
endmodule
`default_nettype wire
